// >>> gpc_cfg.svh
// register offsets, field positions, write masks, reset values and response codes for the gpio pin control block
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
`define GPC_CTRL_OFS 12'h000
`define GPC_CTRL2_OFS 12'h004
`define GPC_SHARED_OUT_OFS 12'h008
`define GPC_WELL_OFS 12'h00C
`define GPC_PWR_LO 2
`define GPC_PWR_HI 3
`define GPC_INT_LO 4
`define GPC_INT_HI 7
`define GPC_BUF_BIT 8
`define GPC_DIR_BIT 9
`define GPC_SRC_BIT 10
`define GPC_POL_BIT 11
`define GPC_MUX_LO 12
`define GPC_MUX_HI 13
`define GPC_DATA_BIT 16
`define GPC_IN_BIT 24
`define GPC_CTRL_WMASK 32'h00013FFC
`define GPC_CTRL2_WMASK 32'h00000030
`define GPC_CTRL_RESET 32'h00000000
`define GPC_CTRL2_RESET 32'h00000000
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2
`endif

// >>> gpc_pkg.sv
// types shared by the gpio pin control block
package gpc_pkg;
    typedef enum logic [1:0] {
        GPC_FN_GPIO,
        GPC_FN_ALT1,
        GPC_FN_ALT2,
        GPC_FN_ALT3
    } gpc_fn_t;
    // pad-facing drive bundle
    typedef struct packed {
        logic out;
        logic oe;
    } gpc_pad_t;
    // one alternate function's drive request
    typedef struct packed {
        logic out;
        logic oe;
    } gpc_alt_t;
endpackage

// >>> gpc_pin_control.sv
// gpio pin control: function mux, polarity, direction, buffer type, axi4-lite registers
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module gpc_pin_control (
    input wire logic aclk, // 100 MHz bus clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic pad_in, // asynchronous pad input level
    input wire logic [3:0] well_on, // power well status per gating code
    input wire gpc_pkg::gpc_alt_t [2:0] alt_drive, // alternate function 1..3 drive
    output gpc_pkg::gpc_pad_t pad_drive, // pad output level and enable
    output logic pad_open_drain, // 1 = open drain buffer
    output logic pad_in_fn, // pad input to selected function
    output logic [3:0] int_det_eff, // interrupt detect setting after polarity
    output logic [5:4] pad_strength // drive strength field of second register
);
    import gpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl;
    logic [31:0] ctrl2;
    logic shared_out;
    logic [31:0] next_ctrl;
    logic [31:0] next_ctrl2;
    logic next_shared_out;

    // pad input sync: three stages, change accepted when stages 2 and 3 agree
    logic [2:0] pin_sync;
    logic pin_level;
    logic [2:0] next_pin_sync;
    logic next_pin_level;
    logic [3:0] well_s1;
    logic [3:0] well_s2;
    logic [3:0] well_s3;
    // well status is a pin as well: per bit, a change counts once stages 2 and 3 agree
    logic [3:0] well_level;
    logic [3:0] next_well_level;

    // axi state
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_aw_held;
    logic next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    // ready outputs come from their own flops, never through an inverter
    logic awready_q;
    logic wready_q;
    logic arready_q;
    logic next_awready;
    logic next_wready;
    logic next_arready;

    // pad outputs
    gpc_pad_t pad_q;
    gpc_pad_t next_pad;
    logic od_q;
    logic next_od;
    logic fn_in_q;
    logic next_fn_in;
    logic [3:0] int_q;
    logic [3:0] next_int;

    ////////////////////////////////////////////////////////////////////////////
    // bus: address and data taken independently, response once both are held
    logic do_write;
    logic in_bit;
    logic [31:0] ctrl_rd;
    logic [31:0] wmask;

    // stretch byte strobes into a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb[i]}};
        end
    end

    // well off forces the input bit high
    assign in_bit = well_level[ctrl[`GPC_PWR_HI:`GPC_PWR_LO]] ? pin_level : 1'b1;

    // reserved bits read zero; bit 16 is the stored value, not the pin
    assign ctrl_rd = (ctrl & `GPC_CTRL_WMASK)
        | ({31'h00000000, in_bit} << `GPC_IN_BIT);

    assign do_write = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_ctrl2 = ctrl2;
        next_shared_out = shared_out;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `GPC_RESP_OKAY;
            unique case (aw_addr[11:2])
                10'(`GPC_CTRL_OFS >> 2): begin
                    // writes never reach reserved or read-only bits
                    next_ctrl = (ctrl & ~(wmask & `GPC_CTRL_WMASK))
                        | (w_data & wmask & `GPC_CTRL_WMASK);
                end
                10'(`GPC_CTRL2_OFS >> 2): begin
                    next_ctrl2 = (ctrl2 & ~(wmask & `GPC_CTRL2_WMASK))
                        | (w_data & wmask & `GPC_CTRL2_WMASK);
                end
                10'(`GPC_SHARED_OUT_OFS >> 2): begin
                    if (w_strb[0]) begin
                        next_shared_out = w_data[0];
                    end
                end
                default: begin
                    next_bresp = `GPC_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
    end

    // read answers one cycle after the address is taken
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = `GPC_RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                10'(`GPC_CTRL_OFS >> 2): next_rdata = ctrl_rd;
                10'(`GPC_CTRL2_OFS >> 2): next_rdata = ctrl2 & `GPC_CTRL2_WMASK;
                10'(`GPC_SHARED_OUT_OFS >> 2): next_rdata = {31'h00000000, shared_out};
                10'(`GPC_WELL_OFS >> 2): next_rdata = {28'h0000000, well_s3};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `GPC_RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad input synchroniser and filter
    always_comb begin
        next_pin_sync = {pin_sync[1:0], pad_in};
        next_pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
        // a bit still settling keeps its old level; the others move on
        next_well_level = (well_s3 & ~(well_s2 ^ well_s3)) | (well_level & (well_s2 ^ well_s3));
    end

    ////////////////////////////////////////////////////////////////////////////
    // function mux, polarity and buffer control
    always_comb begin
        gpc_fn_t fn;
        logic gpio_data;
        fn = gpc_fn_t'(ctrl[`GPC_MUX_HI:`GPC_MUX_LO]);
        gpio_data = ctrl[`GPC_SRC_BIT] ? shared_out : ctrl[`GPC_DATA_BIT];
        next_pad = '0;
        next_int = ctrl[`GPC_INT_HI:`GPC_INT_LO];
        next_od = ctrl[`GPC_BUF_BIT];
        next_fn_in = pin_level;
        unique case (fn)
            GPC_FN_GPIO: begin
                // polarity plays no part here
                next_pad.out = gpio_data;
                next_pad.oe = ctrl[`GPC_DIR_BIT];
            end
            GPC_FN_ALT1, GPC_FN_ALT2, GPC_FN_ALT3: begin
                // the alternate function owns direction
                next_pad.oe = alt_drive[fn - 2'd1].oe;
                next_pad.out = alt_drive[fn - 2'd1].out ^ ctrl[`GPC_POL_BIT];
                next_fn_in = pin_level ^ ctrl[`GPC_POL_BIT];
                next_int = ctrl[`GPC_INT_HI:`GPC_INT_LO]
                    ^ {3'h0, ctrl[`GPC_POL_BIT]};
            end
        endcase
        // open drain never drives high
        if (next_od && next_pad.out) begin
            next_pad.oe = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registering of all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `GPC_CTRL_RESET;
            ctrl2 <= `GPC_CTRL2_RESET;
            shared_out <= 1'b0;
            pin_sync <= 3'h0;
            pin_level <= 1'b0;
            well_level <= 4'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            pad_q <= '0;
            od_q <= 1'b0;
            fn_in_q <= 1'b0;
            int_q <= 4'h0;
            well_s1 <= 4'h0;
            well_s2 <= 4'h0;
            well_s3 <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            ctrl2 <= next_ctrl2;
            shared_out <= next_shared_out;
            pin_sync <= next_pin_sync;
            pin_level <= next_pin_level;
            well_level <= next_well_level;
            awready_q <= next_awready;
            wready_q <= next_wready;
            arready_q <= next_arready;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            pad_q <= next_pad;
            od_q <= next_od;
            fn_in_q <= next_fn_in;
            int_q <= next_int;
            well_s1 <= well_on;
            well_s2 <= well_s1;
            well_s3 <= well_s2;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign pad_drive = pad_q;
    assign pad_open_drain = od_q;
    assign pad_in_fn = fn_in_q;
    assign int_det_eff = int_q;
    assign pad_strength = ctrl2[5:4];
endmodule

// >>> gpc_pad_model.sv
// pad and alternate function model on the far side of the pin control block
`timescale 1ns/1ps
module gpc_pad_model (
    input wire logic ext_lvl, // board level seen when the pad floats
    input wire logic [5:0] alt_req, // {out,oe} asked of functions 3..1
    input wire gpc_pkg::gpc_pad_t pad_drive, // drive from the block
    output gpc_pkg::gpc_alt_t [2:0] alt_drive, // alternate function requests
    output logic pad_in // resolved pad level
);
    import gpc_pkg::*;
    // alternate logic forwards what the bench commands
    assign alt_drive = alt_req;
    // a driven pad wins; a released one shows the board level, never a stale value
    assign pad_in = pad_drive.oe ? pad_drive.out : ext_lvl;
endmodule

// >>> gpc_pin_control_asserts.sv
// bus and pad checks for the gpio pin control block
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_pin_control_asserts (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [11:0] s_axi_araddr, // ar address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [3:0] well_on, // well status
    input wire gpc_pkg::gpc_pad_t pad_drive, // pad drive
    input wire logic pad_open_drain // buffer type
);
    import gpc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    // reserved ranges never show ones, whatever was written
    chk_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFEFEC000) == 32'h0)
        else $error("reserved bits set");
    // well status crosses a synchroniser, so it must have been off for a while
    chk_well_off: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `GPC_CTRL_OFS && well_on == 4'h0 && $past(well_on, 1) == 4'h0 &&
        $past(well_on, 2) == 4'h0 && $past(well_on, 3) == 4'h0 && $past(well_on, 4) == 4'h0
        |=> s_axi_rdata[24]) else $error("input bit low with well off");
    chk_od_no_high: assert property (pad_open_drain && $stable(pad_open_drain) |->
        !(pad_drive.oe && pad_drive.out)) else $error("open drain drove high");
    chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 12'h010 |=> s_axi_rresp == `GPC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind gpc_pin_control gpc_pin_control_asserts u_chk (.*);

// >>> gpc_tb.sv
// self-checking bench for the gpio pin control block
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module testbench;
    import gpc_pkg::*;
    typedef struct {logic [33:0] e; logic [33:0] m;} gpc_note_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, pad_in, pad_open_drain, pad_in_fn, ext_lvl;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, well_on, int_det_eff;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:4] pad_strength;
    logic [5:0] alt_req;
    logic [7:0] seed;
    gpc_alt_t [2:0] alt_drive;
    gpc_pad_t pad_drive;
    gpc_note_t q[$];
    int n_mismatch, total_checks, cyc;
    gpc_pin_control uut (.*);
    gpc_pad_model u_pad (.ext_lvl(ext_lvl), .alt_req(alt_req), .pad_drive(pad_drive),
        .alt_drive(alt_drive), .pad_in(pad_in));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // response is held off a few cycles so the slave must keep it standing
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r = `GPC_RESP_OKAY);
        logic pa, pw;
        q.push_back('{{r, 32'h0}, {2'h3, 32'h0}});
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && s_axi_awready) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (3) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1,
        input logic [1:0] r = `GPC_RESP_OKAY);
        q.push_back('{{r, e}, {2'h3, m}});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // waits out the pad register and the input synchroniser
    task automatic pad(input logic [1:0] e);
        repeat (6) @(posedge aclk);
        chk("pad_drive", {32'h0, e}, {32'h0, pad_drive});
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // hang guard and the watcher that settles each bus note
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            gpc_note_t n;
            n = q.pop_front();
            chk("bus", n.e & n.m, (s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} :
                {s_axi_bresp, 32'h0}) & n.m);
        end
    end
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        well_on = 4'hF;
        ext_lvl = 1'b1;
        alt_req = 6'h0;
        seed = 8'h52;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // let pad and well synchronisers settle so bit 24 shows the real pin
        repeat (6) @(posedge aclk);
        rd(`GPC_CTRL_OFS, 32'h01000000);
        rd(`GPC_CTRL2_OFS, 32'h0);
        wr(`GPC_CTRL_OFS, 32'hFFFFFFFF);
        rd(`GPC_CTRL_OFS, 32'h00013FFC, 32'hFEFFFFFF);
        wr(`GPC_CTRL2_OFS, 32'hFFFFFFFF);
        rd(`GPC_CTRL2_OFS, 32'h00000030);
        chk("pad_strength", 34'h3, {32'h0, pad_strength});
        wr(`GPC_CTRL_OFS, 32'h0);
        ext_lvl <= 1'b0;
        well_on <= 4'h0;
        // pin and well settle low on the same cycle, so a one here can only come from the dead well
        repeat (6) @(posedge aclk);
        rd(`GPC_CTRL_OFS, 32'h01000000);
        well_on <= 4'hF;
        repeat (6) @(posedge aclk);
        rd(`GPC_CTRL_OFS, 32'h0);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(`GPC_CTRL_OFS, {15'h0, seed[0], 16'h0200});
            pad({seed[0], 1'b1});
            wr(`GPC_SHARED_OUT_OFS, {31'h0, ~seed[0]});
            wr(`GPC_CTRL_OFS, {15'h0, seed[0], 16'h0600});
            pad({~seed[0], 1'b1});
            rd(`GPC_CTRL_OFS, {7'h0, ~seed[0], 7'h0, seed[0], 16'h0600});
            wr(`GPC_CTRL_OFS, {15'h0, seed[0], 16'h0A00});
            pad({seed[0], 1'b1});
            chk("int_det_eff", 34'h0, {30'h0, int_det_eff});
            chk("pad_in_fn", {33'h0, seed[0]}, {33'h0, pad_in_fn});
            wr(`GPC_CTRL_OFS, {15'h0, seed[0], 16'h0300});
            pad({seed[0], ~seed[0]});
            chk("pad_open_drain", 34'h1, {33'h0, pad_open_drain});
        end
        $display("gpio output test done");
        for (int f = 1; f < 4; f++) begin
            for (int p = 0; p < 2; p++) begin
                seed = lfsr(seed);
                alt_req <= seed[5:0];
                wr(`GPC_CTRL_OFS, {18'h0, f[1:0], p[0], 11'h0});
                pad({seed[2*f-1] ^ p[0], seed[2*f-2]});
                chk("int_det_eff", {33'h0, p[0]}, {30'h0, int_det_eff});
                rd(`GPC_CTRL_OFS, {7'h0, seed[2*f-2] ? seed[2*f-1] ^ p[0] : 1'b0,
                    10'h0, f[1:0], p[0], 11'h0});
                chk("pad_in_fn", {33'h0, (seed[2*f-2] ? seed[2*f-1] ^ p[0] : 1'b0) ^ p[0]},
                    {33'h0, pad_in_fn});
            end
        end
        $display("alternate function test done");
        rd(12'h010, 32'h0, '1, `GPC_RESP_SLVERR);
        wr(12'h010, 32'hFFFFFFFF, `GPC_RESP_SLVERR);
        $display("unmapped test done");
        report_and_stop();
    end
endmodule
